// ===== src/trlw_core.sv
// Rule table block: staging cache, prefix-match and egress rewrite tables, and lookup scanner.
// Assumes one clock domain; software on Avalon-MM, lookup requests from logic on the same clock.
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "trlw_regs.svh"
module trlw_core
  import trlw_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic lookup_req_in,
  input wire logic lookup_table_in,
  input wire logic [34:0] lookup_key_in,
  input wire logic [3:0] lookup_default_in,
  output logic lookup_ready_out,
  output logic lookup_done_out,
  output logic lookup_hit_out,
  output logic lookup_miss_out,
  output logic [284:0] lookup_action_out,
  output logic [9:0] lookup_addr_out
);
  trlw_state_s s_reg;
  trlw_state_s s_next;

  // Table storage; valid and hit-counter bits are reset, data words are not.
  logic [35:0] pm_ent [0:`TRLW_PM_DEPTH-1];
  logic [35:0] pm_msk [0:`TRLW_PM_DEPTH-1];
  logic [69:0] pm_act [0:`TRLW_PM_DEPTH-1];
  logic [`TRLW_PM_DEPTH-1:0] pm_vld;
  logic [`TRLW_PM_DEPTH-1:0] pm_cnt;
  logic [29:0] er_ent [0:`TRLW_ER_DEPTH-1];
  logic [29:0] er_msk [0:`TRLW_ER_DEPTH-1];
  logic [284:0] er_act [0:`TRLW_ER_DEPTH-1];
  logic [`TRLW_ER_DEPTH-1:0] er_vld;
  logic [`TRLW_ER_DEPTH-1:0] er_cnt;

  logic busy;
  logic wr_go;
  logic rd_go;
  logic shot_go;
  logic store;
  logic addr_ok;
  logic match;
  logic last;
  logic [9:0] def_addr;
  logic [5:0] word;

  // Mask bit 0 means care; an address only matches when its rule is enabled.
  function automatic logic tcam_match(input logic [35:0] key, input logic [35:0] e,
                                      input logic [35:0] m, input logic vld);
    tcam_match = vld && (((key ^ e) & ~m) == 36'h0);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  assign busy = (s_reg.state != TRLW_IDLE);
  assign word = avs_address_in[7:2];
  assign wr_go = avs_write_in && !busy;
  assign rd_go = avs_read_in && s_reg.rvalid;
  assign avs_waitrequest_out = (avs_read_in && !s_reg.rvalid) || (avs_write_in && busy);
  assign avs_readdata_out = s_reg.rdata;
  assign shot_go = wr_go && (avs_address_in == `TRLW_OFF_CTRL) && avs_byteenable_in[0] &&
                   avs_writedata_in[`TRLW_CTRL_SHOT];
  assign lookup_ready_out = !busy && !shot_go;
  assign lookup_done_out = s_reg.done;
  assign lookup_hit_out = s_reg.hit;
  assign lookup_miss_out = s_reg.miss;
  assign lookup_action_out = s_reg.lact;
  assign lookup_addr_out = s_reg.laddr;

  // Out-of-range targets complete the command but store nothing.
  assign addr_ok = s_reg.tbl ? (s_reg.addr < 13'(`TRLW_ER_DEPTH)) :
                   (s_reg.addr < 13'(`TRLW_PM_DEPTH));
  assign store = (s_reg.state == TRLW_COPY) && (s_reg.copy_cnt == 2'h1) && addr_ok;

  // Prefix keys carry the one-address marker 1 in bit 0, so only entries whose first
  // word holds that marker, or whose mask bit 0 is set, can start a match. Zeroed cared bits match only zero.
  always_comb begin
    if (s_reg.ltbl) begin
      match = tcam_match({6'h00, s_reg.key[29:0]}, {6'h00, er_ent[s_reg.idx]},
                         {6'h00, er_msk[s_reg.idx]}, er_vld[s_reg.idx]);
      last = (s_reg.idx == `TRLW_ER_LAST);
    end else begin
      match = tcam_match({s_reg.key, 1'b1}, pm_ent[s_reg.idx],
                         pm_msk[s_reg.idx], pm_vld[s_reg.idx]);
      last = (s_reg.idx == `TRLW_PM_LAST);
    end
  end
  assign def_addr = `TRLW_ER_BASE_DEF + {6'h00, s_reg.dsel};

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.rvalid = avs_read_in && !s_reg.rvalid;
    if (avs_read_in && !s_reg.rvalid) begin
      s_next.rdata = 32'h0;
      if (word >= 6'h0C && word <= 6'h14) begin
        s_next.rdata = s_reg.act[(word - 6'h0C)*32 +: 32];
      end
      unique case (avs_address_in)
        `TRLW_OFF_CTRL: s_next.rdata = {16'h0, s_reg.addr, busy, s_reg.tbl, 1'b0};
        `TRLW_OFF_ENA: s_next.rdata = {31'h0, s_reg.ena};
        `TRLW_OFF_ENT0: s_next.rdata = s_reg.ent[31:0];
        `TRLW_OFF_ENT1: s_next.rdata = {28'h0, s_reg.ent[35:32]};
        `TRLW_OFF_MSK0: s_next.rdata = s_reg.msk[31:0];
        `TRLW_OFF_MSK1: s_next.rdata = {28'h0, s_reg.msk[35:32]};
        `TRLW_OFF_CNT: s_next.rdata = {31'h0, s_reg.cnt};
        `TRLW_OFF_STAT: s_next.rdata = {6'h0, s_reg.laddr, 14'h0, s_reg.miss, s_reg.hit};
        default: ;
      endcase
    end
    if (wr_go) begin
      if (word >= 6'h0C && word <= 6'h14) begin
        s_next.act[(word - 6'h0C)*32 +: 32] =
          merge(s_reg.act[(word - 6'h0C)*32 +: 32], avs_writedata_in, avs_byteenable_in);
      end
      unique case (avs_address_in)
        `TRLW_OFF_ENA: s_next.ena = avs_byteenable_in[0] ? avs_writedata_in[0] : s_reg.ena;
        `TRLW_OFF_ENT0: s_next.ent[31:0] = merge(s_reg.ent[31:0], avs_writedata_in,
                                                 avs_byteenable_in);
        `TRLW_OFF_ENT1: s_next.ent[35:32] = avs_byteenable_in[0] ? avs_writedata_in[3:0] :
                                            s_reg.ent[35:32];
        `TRLW_OFF_MSK0: s_next.msk[31:0] = merge(s_reg.msk[31:0], avs_writedata_in, avs_byteenable_in);
        `TRLW_OFF_MSK1: s_next.msk[35:32] = avs_byteenable_in[0] ? avs_writedata_in[3:0] :
                                            s_reg.msk[35:32];
        `TRLW_OFF_CNT: s_next.cnt = avs_byteenable_in[0] ? avs_writedata_in[0] : s_reg.cnt;
        `TRLW_OFF_CTRL: begin
          if (avs_byteenable_in[0] && avs_writedata_in[`TRLW_CTRL_CLEAR]) begin
            s_next.ent = 36'h0;
            s_next.msk = 36'h0;
            s_next.act = 288'h0;
            s_next.cnt = 1'b0;
            s_next.ena = 1'b0;
          end
          if (shot_go) begin
            s_next.tbl = avs_writedata_in[`TRLW_CTRL_TBL];
            s_next.addr = avs_writedata_in[`TRLW_CTRL_ADDR_MSB:`TRLW_CTRL_ADDR_LSB];
            s_next.copy_cnt = `TRLW_COPY_CYCLES;
            s_next.state = TRLW_COPY;
          end
        end
        default: ;
      endcase
    end
    unique case (s_reg.state)
      TRLW_IDLE: begin
        if (lookup_req_in && lookup_ready_out) begin
          s_next.state = TRLW_SCAN;
          s_next.idx = 10'h0;
          s_next.ltbl = lookup_table_in;
          s_next.key = lookup_key_in;
          s_next.dsel = lookup_default_in;
        end
      end
      TRLW_COPY: begin
        s_next.copy_cnt = s_reg.copy_cnt - 2'h1;
        if (s_reg.copy_cnt == 2'h1) begin
          s_next.state = TRLW_IDLE;
        end
      end
      TRLW_SCAN: begin
        s_next.idx = s_reg.idx + 10'h1;
        if (match || last) begin
          s_next.state = TRLW_IDLE;
          s_next.done = 1'b1;
          s_next.hit = match;
          s_next.laddr = s_reg.idx;
          s_next.miss = 1'b0;
          if (match) begin
            s_next.lact = s_reg.ltbl ? er_act[s_reg.idx] : {215'h0, pm_act[s_reg.idx]};
          end else if (s_reg.ltbl && s_reg.dsel < `TRLW_ER_DEFAULTS) begin
            s_next.lact = er_act[def_addr];
            s_next.laddr = def_addr;
          end else begin
            s_next.lact = 285'h0;
            s_next.miss = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
      s_reg.state <= TRLW_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pm_vld <= '0;
      pm_cnt <= '0;
      er_vld <= '0;
      er_cnt <= '0;
    end else begin
      if (store && !s_reg.tbl) begin
        pm_vld[s_reg.addr[9:0]] <= s_reg.ena;
        pm_cnt[s_reg.addr[9:0]] <= s_reg.cnt;
      end else if (store) begin
        er_vld[s_reg.addr[9:0]] <= s_reg.ena;
        er_cnt[s_reg.addr[9:0]] <= s_reg.cnt;
      end
      if (s_reg.state == TRLW_SCAN && match && !s_reg.ltbl) begin
        pm_cnt[s_reg.idx] <= 1'b1;
      end else if (s_reg.state == TRLW_SCAN && match) begin
        er_cnt[s_reg.idx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (store && !s_reg.tbl) begin
      pm_ent[s_reg.addr[9:0]] <= s_reg.ent;
      pm_msk[s_reg.addr[9:0]] <= s_reg.msk;
      pm_act[s_reg.addr[9:0]] <= s_reg.act[69:0];
    end else if (store) begin
      er_ent[s_reg.addr[9:0]] <= s_reg.ent[29:0];
      er_msk[s_reg.addr[9:0]] <= s_reg.msk[29:0];
      er_act[s_reg.addr[9:0]] <= s_reg.act[284:0];
    end
  end

  // Checks on the cache, the command handshake and the lookup results.
  logic past_valid;
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      past_valid <= 1'b0;
    end else begin
      past_valid <= 1'b1;
    end
  end

  busy_set_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    shot_go |=> busy && s_reg.state == TRLW_COPY)
    else $error("Update command did not raise busy.");

  busy_hold_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    shot_go |=> busy[*2] ##1 !busy)
    else $error("Busy did not last exactly the copy time.");

  cache_clear_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    wr_go && avs_address_in == `TRLW_OFF_CTRL && avs_byteenable_in[0] && avs_writedata_in[0]
    |=> s_reg.ent == 36'h0 && s_reg.msk == 36'h0 && s_reg.act == 288'h0 && !s_reg.cnt && !s_reg.ena)
    else $error("Cache clear left data behind.");

  busy_stall_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    avs_write_in && busy |-> avs_waitrequest_out ##1 $stable(s_reg.ent) && $stable(s_reg.act))
    else $error("Cache changed while busy.");

  pm_store_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    store && !s_reg.tbl |=> pm_vld[$past(s_reg.addr[9:0])] == $past(s_reg.ena) &&
    pm_ent[$past(s_reg.addr[9:0])] == $past(s_reg.ent))
    else $error("Prefix entry not stored at target address.");

  pm_miss_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.done && !s_reg.ltbl && !s_reg.hit |-> s_reg.miss && s_reg.lact == 285'h0)
    else $error("Prefix no-match not reported as miss.");

  er_default_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.done && s_reg.ltbl && !s_reg.hit && s_reg.dsel < `TRLW_ER_DEFAULTS
    |-> !s_reg.miss && s_reg.laddr == 10'h200 + {6'h00, s_reg.dsel})
    else $error("Egress default rule address wrong.");

  scan_range_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.state == TRLW_SCAN && s_reg.ltbl |-> s_reg.idx <= `TRLW_ER_LAST)
    else $error("Egress scan ran past its key addresses.");

  read_wait_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    avs_read_in && !s_reg.rvalid && past_valid |-> avs_waitrequest_out ##1 (rd_go || !avs_read_in))
    else $error("Read not answered on the second cycle.");

  er_store_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    store && s_reg.tbl |=> er_vld[$past(s_reg.addr[9:0])] == $past(s_reg.ena) &&
    er_act[$past(s_reg.addr[9:0])] == $past(s_reg.act[284:0]))
    else $error("Egress rule not stored at target address.");

  cmd_load_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    shot_go |=> s_reg.addr == $past(avs_writedata_in[`TRLW_CTRL_ADDR_MSB:`TRLW_CTRL_ADDR_LSB]) &&
    s_reg.tbl == $past(avs_writedata_in[`TRLW_CTRL_TBL]))
    else $error("Update command target not captured.");

  pm_act_width_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.done && !s_reg.ltbl |-> s_reg.lact[284:70] == 215'h0)
    else $error("Prefix action wider than one address.");

  er_nodef_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.done && s_reg.ltbl && !s_reg.hit && s_reg.dsel >= `TRLW_ER_DEFAULTS |-> s_reg.miss)
    else $error("Egress lookup without default not a miss.");

  er_hit_range_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.done && s_reg.ltbl && s_reg.hit |-> s_reg.laddr <= `TRLW_ER_LAST && !s_reg.miss)
    else $error("Egress hit outside key addresses.");

  scan_end_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.state == TRLW_SCAN && (match || last) |=> s_reg.done && s_reg.state == TRLW_IDLE)
    else $error("Scan did not end with a result.");

  pm_miss_c: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.done && s_reg.miss && !s_reg.ltbl);

  update_c: cover property (@(posedge ref_clk_in) disable iff (!resetn_in) shot_go ##3 !busy);
  pm_hit_c: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.done && s_reg.hit && !s_reg.ltbl);
  er_def_c: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_reg.done && !s_reg.hit && s_reg.ltbl && !s_reg.miss);
  stall_c: cover property (@(posedge ref_clk_in) disable iff (!resetn_in) avs_write_in && busy);
endmodule

// ===== src/trlw_pkg.sv
// Types of the rule table block: controller states and the packed controller state.
// Assumes trlw_regs.svh is on the include path.
`include "trlw_regs.svh"
package trlw_pkg;
  typedef enum logic [2:0] {
    TRLW_IDLE = 3'b001,
    TRLW_COPY = 3'b010,
    TRLW_SCAN = 3'b100
  } trlw_state_e;
  typedef struct packed {
    trlw_state_e state;
    logic [1:0] copy_cnt;
    logic tbl;
    logic [12:0] addr;
    logic [35:0] ent;
    logic [35:0] msk;
    logic [287:0] act;
    logic cnt;
    logic ena;
    logic [31:0] rdata;
    logic rvalid;
    logic [9:0] idx;
    logic ltbl;
    logic [34:0] key;
    logic [3:0] dsel;
    logic done;
    logic hit;
    logic miss;
    logic [284:0] lact;
    logic [9:0] laddr;
  } trlw_state_s;
endpackage

// ===== src/trlw_regs.svh
// Register offsets, field positions, table sizes and timing counts of the rule table block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef TRLW_REGS_SVH
`define TRLW_REGS_SVH
`define TRLW_OFF_CTRL 8'h00
`define TRLW_OFF_ENA 8'h04
`define TRLW_OFF_ENT0 8'h10
`define TRLW_OFF_ENT1 8'h14
`define TRLW_OFF_MSK0 8'h20
`define TRLW_OFF_MSK1 8'h24
`define TRLW_OFF_ACT0 8'h30
`define TRLW_OFF_ACT8 8'h50
`define TRLW_OFF_CNT 8'h60
`define TRLW_OFF_STAT 8'h64
`define TRLW_CTRL_CLEAR 0
`define TRLW_CTRL_TBL 1
`define TRLW_CTRL_SHOT 2
`define TRLW_CTRL_ADDR_LSB 3
`define TRLW_CTRL_ADDR_MSB 15
`define TRLW_PM_DEPTH 1024
`define TRLW_PM_LAST 10'h3FF
`define TRLW_ER_LAST 10'h1FF
`define TRLW_ER_BASE_DEF 10'h200
`define TRLW_ER_DEFAULTS 4'hB
`define TRLW_ER_DEPTH 523
`define TRLW_ENT_W 36
`define TRLW_PM_ACT_W 70
`define TRLW_ER_ENT_W 30
`define TRLW_ER_ACT_W 285
`define TRLW_COPY_CYCLES 2'h2
`endif

// ===== testbench/tb_trlw_core.sv
// Self-checking bench of the rule table block: bus tasks, lookups, queued expectations.
// Assumes trlw_core and trlw_regs.svh on the include path; one 40 MHz clock.
`timescale 1ns/1ps
`include "trlw_regs.svh"
module tb_trlw_core;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic lookup_req_in = 1'b0;
  logic lookup_table_in = 1'b0;
  logic [34:0] lookup_key_in = 35'h0;
  logic [3:0] lookup_default_in = 4'hF;
  logic lookup_ready_out, lookup_done_out, lookup_hit_out, lookup_miss_out;
  logic [284:0] lookup_action_out;
  logic [9:0] lookup_addr_out;
  int err_total = 0;
  int n_compared = 0;
  time rd_rel = 0;
  time wr_rel = 0;
  logic [63:0] rd_q[$];
  logic [296:0] lk_q[$];
  logic [296:0] lk_m[$];
  logic [31:0] last_rd;
  logic [34:0] key;
  logic [287:0] act;
  logic [9:0] pa;
  logic [12:0] pb;
  logic [35:0] ent;
  logic [7:0] clr_regs[6] = '{8'h10, 8'h14, 8'h30, 8'h50, 8'h60, 8'h04};

  trlw_core dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .lookup_req_in(lookup_req_in),
    .lookup_table_in(lookup_table_in), .lookup_key_in(lookup_key_in),
    .lookup_default_in(lookup_default_in), .lookup_ready_out(lookup_ready_out),
    .lookup_done_out(lookup_done_out), .lookup_hit_out(lookup_hit_out), .lookup_miss_out(lookup_miss_out),
    .lookup_action_out(lookup_action_out), .lookup_addr_out(lookup_addr_out));

  always #12.5 ref_clk_in = ~ref_clk_in;

  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
    n_compared++;
    if ((g & m) !== (e & m)) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_lk(input logic [296:0] e, input logic [296:0] m, input logic [296:0] g);
    n_compared++;
    if ((g & m) !== (e & m)) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Result watcher: pairs each answered read or finished lookup with the oldest note.
  always @(posedge ref_clk_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && rd_q.size() > 0) begin
      if (rd_q[0][63:32] != 32'h0) begin
        cmp_rd(rd_q[0][31:0], rd_q[0][63:32], avs_readdata_out);
      end
      void'(rd_q.pop_front());
    end
    if (lookup_done_out === 1'b1 && lk_q.size() > 0) begin
      cmp_lk(lk_q.pop_front(), lk_m.pop_front(),
        {lookup_hit_out, lookup_miss_out, lookup_addr_out, lookup_action_out});
    end
  end

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    if ($time == wr_rel) @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
    wr_rel = $time;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    if ($time == rd_rel) @(posedge ref_clk_in);
    rd_q.push_back({m, e});
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    last_rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    rd_rel = $time;
  endtask

  task automatic upd(input logic [31:0] c);
    bus_wr(`TRLW_OFF_CTRL, c);
    bus_rd(`TRLW_OFF_CTRL, 32'h4, 32'h4);
    do begin
      bus_rd(`TRLW_OFF_CTRL, 32'h0, 32'h0);
    end while (last_rd[2] !== 1'b0);
  endtask

  task automatic wr_rule(input logic t, input logic [12:0] a, input logic [35:0] e, input logic [287:0] d);
    bus_wr(`TRLW_OFF_CTRL, 32'h1);
    bus_wr(`TRLW_OFF_ENT0, e[31:0]);
    bus_wr(`TRLW_OFF_ENT1, {28'h0, e[35:32]});
    for (int k = 0; k < 9; k++) begin
      bus_wr(8'(`TRLW_OFF_ACT0 + 4 * k), d[32 * k +: 32]);
    end
    bus_wr(`TRLW_OFF_ENA, 32'h1);
    upd({16'h0, a, 3'h4} | {30'h0, t, 1'b0});
  endtask

  task automatic look(input logic t, input logic [34:0] k, input logic [3:0] n, input logic [296:0] e,
    input logic [296:0] m);
    lk_q.push_back(e);
    lk_m.push_back(m);
    lookup_table_in <= t;
    lookup_key_in <= k;
    lookup_default_in <= n;
    lookup_req_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (lookup_ready_out !== 1'b1);
    lookup_req_in <= 1'b0;
    do begin
      @(posedge ref_clk_in);
    end while (lookup_done_out !== 1'b1);
  endtask

  initial begin
    void'($urandom(33360));
    repeat (8) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(posedge ref_clk_in);
    bus_rd(`TRLW_OFF_CTRL, 32'h0, '1);
    bus_rd(`TRLW_OFF_STAT, 32'h0, '1);
    bus_rd(8'h7C, 32'h0, '1);
    $display("test reset_values done");
    key = 35'({$urandom, $urandom});
    act = 288'({$urandom, $urandom, $urandom});
    act[287:70] = '0;
    pa = 10'($urandom);
    wr_rule(1'b0, {3'h0, pa}, {key, 1'b1}, act);
    look(1'b0, key, 4'hF, {2'b10, pa, act[284:0]}, '1);
    look(1'b0, key ^ 35'h1, 4'hF, {2'b01, 295'h0}, {2'b11, 295'h0});
    $display("test prefix_rule done");
    // A cache write issued right after an update must stall until the copy is over.
    bus_wr(`TRLW_OFF_CTRL, {16'h0, 3'h0, pa, 3'h4});
    bus_wr(`TRLW_OFF_ENT0, 32'h0);
    look(1'b0, key, 4'hF, {2'b10, pa, act[284:0]}, '1);
    bus_wr(`TRLW_OFF_ENT1, 32'hF);
    bus_wr(`TRLW_OFF_ACT8, 32'hFFFFFFFF);
    bus_wr(`TRLW_OFF_CNT, 32'h1);
    bus_wr(`TRLW_OFF_CTRL, 32'h1);
    for (int k = 0; k < 6; k++) begin
      bus_rd(clr_regs[k], 32'h0, '1);
    end
    upd({16'h0, 3'h0, pa, 3'h5});
    look(1'b0, key, 4'hF, {2'b01, 295'h0}, {2'b11, 295'h0});
    $display("test stall_clear_remove done");
    // A four-address rule goes in from its highest offset down, each offset with its zero or marker bits.
    pb = {3'h0, pa[9:2], 2'b00};
    for (int o = 3; o >= 0; o--) begin
      int w;
      w = (o == 0) ? 3 : ((o == 2) ? 2 : 1);
      key = 35'({$urandom, $urandom});
      ent = 36'({key, 1'b0} << (w - 1)) | ((o == 0) ? 36'h4 : 36'h0);
      act = (288'({$urandom, $urandom, $urandom}) & ((288'h1 << ((o == 3) ? 46 : 70 - w)) - 288'h1)) << w;
      if (o == 0) act[2] = 1'b1;
      wr_rule(1'b0, pb + 13'(o), ent, act);
    end
    look(1'b0, ent[35:1], 4'hF, {2'b01, 295'h0}, {2'b11, 295'h0});
    $display("test wide_rule done");
    key = 35'($urandom) & 35'h3FFFFFFF;
    for (int k = 0; k < 9; k++) begin
      act[32 * k +: 32] = $urandom;
    end
    act[287:285] = '0;
    wr_rule(1'b1, 13'd215, {6'h0, key[29:0]}, act);
    bus_rd(`TRLW_OFF_CTRL, {16'h0, 13'd215, 3'h2}, '1);
    look(1'b1, key, 4'hB, {2'b10, 10'd215, act[284:0]}, '1);
    for (int n = 0; n < 11; n++) begin
      act[31:0] = $urandom;
      wr_rule(1'b1, 13'(512 + n), 36'h0, act);
      look(1'b1, key ^ 35'h1, 4'(n), {2'b00, 10'(512 + n), act[284:0]}, '1);
    end
    look(1'b1, key ^ 35'h1, 4'hB, {2'b01, 295'h0}, {2'b11, 295'h0});
    $display("test egress_rules done");
    close_out();
  end

  initial begin
    #(25 * 60000);
    err_total++;
    close_out();
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
endmodule
